// file: src/urbs_icr_mem.sv
`timescale 1ns/1ps
module urbs_idx_mem
  import urbs_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // clock, no reset
  input  wire logic             clk,
  // write port
  input  wire logic             we,
  input  wire logic [7:0]       waddr,
  input  wire urbs_byte_t       wdata,
  // read port, registered
  input  wire logic [7:0]       raddr,
  output urbs_byte_t            rdata_q
);
  localparam int AW = $clog2(DEPTH);

  urbs_byte_t mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we && (waddr < 8'(DEPTH))) begin
      mem[waddr[AW-1:0]] <= wdata;
    end
  end

  // out-of-range index reads as zero
  always_ff @(posedge clk) begin
    if (raddr < 8'(DEPTH)) begin
      rdata_q <= mem[raddr[AW-1:0]];
    end else begin
      rdata_q <= 8'h00;
    end
  end
endmodule : urbs_idx_mem

// file: src/urbs_map.svh
// Function
// - three address lines, two control registers, the key flag and the scratch pad index pick each register.
// - line control bit 7 maps the divisor bytes at addresses 0 and 1.
// - writing key 0xbf to line control opens the 650-compatible set.
// - key write sets bit 7 and keeps the previous low seven bits.
// - additional control bit 7 makes the 950-specific registers readable.
// - additional control bit 6 makes the indexed control set readable.
`ifndef URBS_MAP_SVH
`define URBS_MAP_SVH

// address offsets
`define URBS_A_DATA    3'h0
`define URBS_A_INTEN   3'h1
`define URBS_A_FIFO    3'h2
`define URBS_A_LINE    3'h3
`define URBS_A_MODEM   3'h4
`define URBS_A_LSR     3'h5
`define URBS_A_MSR     3'h6
`define URBS_A_SPR     3'h7

// field positions
`define URBS_LINE_DIV_BIT  7
`define URBS_ADD_950_BIT   7
`define URBS_ADD_IDX_BIT   6

// key value and indexes
`define URBS_LINE_KEY  8'hbf
`define URBS_ADD_IDX0  8'h00

// reset values
`define URBS_LINE_RST  8'h00
`define URBS_REG_RST   8'h00

`endif

// file: src/urbs_pkg.sv
package urbs_pkg;
  typedef enum logic [1:0] {
    BANK_NORMAL,
    BANK_DIVISOR,
    BANK_ENH650
  } urbs_bank_t;
  typedef logic [7:0] urbs_byte_t;
endpackage : urbs_pkg

// file: src/urbs_top.sv
`timescale 1ns/1ps
`include "urbs_map.svh"
module urbs_top
  import urbs_pkg::*;
#(
  parameter int IDX_DEPTH = 16
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host register port
  input  wire logic [2:0] addr,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire urbs_byte_t wdata,
  output urbs_byte_t      rdata_q,
  // uart core side
  input  wire urbs_byte_t rx_data,
  input  wire urbs_byte_t int_ident,
  input  wire urbs_byte_t line_status,
  input  wire urbs_byte_t modem_status,
  input  wire urbs_byte_t adv_status,
  input  wire urbs_byte_t rx_level,
  input  wire urbs_byte_t tx_level,
  output urbs_byte_t      tx_holding_q,
  output logic            tx_load_q,
  output logic            rx_read_q,
  output urbs_byte_t      fifo_control_q,
  output logic            fifo_wr_q,
  output urbs_byte_t      int_enable_q,
  output urbs_byte_t      line_control_q,
  output urbs_byte_t      modem_control_q,
  output urbs_byte_t      divisor_low_q,
  output urbs_byte_t      divisor_high_byte_q,
  output urbs_byte_t      additional_control_q,
  output urbs_byte_t      enh_flow_q,
  output logic            enh650_open_q
);
  urbs_byte_t enh_char_q [4];
  urbs_byte_t scratch_q;
  urbs_byte_t idx_rdata;
  urbs_bank_t bank;
  logic       idx_we;

  // bank from line control state
  function automatic urbs_bank_t bank_of(logic key, urbs_byte_t lc);
    if (key) begin
      return BANK_ENH650;
    end else if (lc[`URBS_LINE_DIV_BIT]) begin
      return BANK_DIVISOR;
    end
    return BANK_NORMAL;
  endfunction : bank_of

  function automatic logic is_divisor(urbs_bank_t b, logic [2:0] a);
    return (b != BANK_NORMAL) && (a == `URBS_A_DATA || a == `URBS_A_INTEN);
  endfunction : is_divisor

  function automatic logic is_enh(urbs_bank_t b, logic [2:0] a);
    return (b == BANK_ENH650) && (a == `URBS_A_FIFO || a >= `URBS_A_MODEM);
  endfunction : is_enh

  assign bank = bank_of(enh650_open_q, line_control_q);
  assign idx_we = wr_stb && (addr == `URBS_A_LSR) && !is_enh(bank, addr);

  // line control and key detect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_control_q <= `URBS_LINE_RST;
      enh650_open_q  <= 1'b0;
    end else if (wr_stb && addr == `URBS_A_LINE) begin
      if (wdata == `URBS_LINE_KEY) begin
        line_control_q <= {1'b1, line_control_q[6:0]};
        enh650_open_q  <= 1'b1;
      end else begin
        line_control_q <= wdata;
        enh650_open_q  <= 1'b0;
      end
    end
  end

  // divisor latches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divisor_low_q       <= `URBS_REG_RST;
      divisor_high_byte_q <= `URBS_REG_RST;
    end else if (wr_stb && is_divisor(bank, addr)) begin
      if (addr == `URBS_A_DATA) begin
        divisor_low_q <= wdata;
      end else begin
        divisor_high_byte_q <= wdata;
      end
    end
  end

  // 650 compatible set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enh_flow_q <= `URBS_REG_RST;
      for (int i = 0; i < 4; i++) begin
        enh_char_q[i] <= `URBS_REG_RST;
      end
    end else if (wr_stb && is_enh(bank, addr)) begin
      if (addr == `URBS_A_FIFO) begin
        enh_flow_q <= wdata;
      end else begin
        enh_char_q[addr[1:0]] <= wdata;
      end
    end
  end

  // normal bank registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_holding_q    <= `URBS_REG_RST;
      fifo_control_q  <= `URBS_REG_RST;
      int_enable_q    <= `URBS_REG_RST;
      modem_control_q <= `URBS_REG_RST;
      scratch_q       <= `URBS_REG_RST;
      tx_load_q       <= 1'b0;
      fifo_wr_q       <= 1'b0;
    end else begin
      tx_load_q <= 1'b0;
      fifo_wr_q <= 1'b0;
      if (wr_stb && bank == BANK_NORMAL) begin
        unique case (addr)
          `URBS_A_DATA: begin
            tx_holding_q <= wdata;
            tx_load_q    <= 1'b1;
          end
          `URBS_A_INTEN: int_enable_q <= wdata;
          `URBS_A_FIFO: begin
            fifo_control_q <= wdata;
            fifo_wr_q      <= 1'b1;
          end
          `URBS_A_MODEM: modem_control_q <= wdata;
          `URBS_A_SPR: scratch_q <= wdata;
          default: ;
        endcase
      end else if (wr_stb && bank == BANK_DIVISOR) begin
        unique case (addr)
          `URBS_A_FIFO: begin
            fifo_control_q <= wdata;
            fifo_wr_q      <= 1'b1;
          end
          `URBS_A_MODEM: modem_control_q <= wdata;
          `URBS_A_SPR: scratch_q <= wdata;
          default: ;
        endcase
      end
    end
  end

  // additional control, index zero of the indexed set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      additional_control_q <= `URBS_REG_RST;
    end else if (idx_we && scratch_q == `URBS_ADD_IDX0) begin
      additional_control_q <= wdata;
    end
  end

  urbs_idx_mem #(
    .DEPTH (IDX_DEPTH)
  ) u_idx_mem (
    .clk     (clk),
    .we      (idx_we),
    .waddr   (scratch_q),
    .wdata   (wdata),
    .raddr   (scratch_q),
    .rdata_q (idx_rdata)
  );

  // read path, answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q   <= `URBS_REG_RST;
      rx_read_q <= 1'b0;
    end else begin
      rx_read_q <= 1'b0;
      if (rd_stb) begin
        if (is_divisor(bank, addr)) begin
          rdata_q <= (addr == `URBS_A_DATA) ? divisor_low_q
                                            : divisor_high_byte_q;
        end else if (is_enh(bank, addr)) begin
          rdata_q <= (addr == `URBS_A_FIFO) ? enh_flow_q
                                            : enh_char_q[addr[1:0]];
        end else if (additional_control_q[`URBS_ADD_950_BIT] &&
                     addr == `URBS_A_INTEN) begin
          rdata_q <= adv_status;
        end else if (additional_control_q[`URBS_ADD_950_BIT] &&
                     addr == `URBS_A_LINE) begin
          rdata_q <= rx_level;
        end else if (additional_control_q[`URBS_ADD_950_BIT] &&
                     addr == `URBS_A_MODEM) begin
          rdata_q <= tx_level;
        end else if (additional_control_q[`URBS_ADD_IDX_BIT] &&
                     addr == `URBS_A_LSR) begin
          rdata_q <= idx_rdata;
        end else begin
          unique case (addr)
            `URBS_A_DATA: begin
              rdata_q   <= rx_data;
              rx_read_q <= 1'b1;
            end
            `URBS_A_INTEN: rdata_q <= int_enable_q;
            `URBS_A_FIFO:  rdata_q <= int_ident;
            `URBS_A_LINE:  rdata_q <= line_control_q;
            `URBS_A_MODEM: rdata_q <= modem_control_q;
            `URBS_A_LSR:   rdata_q <= line_status;
            `URBS_A_MSR:   rdata_q <= modem_status;
            `URBS_A_SPR:   rdata_q <= scratch_q;
          endcase
        end
      end
    end
  end

  // checks
  key_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stb && addr == `URBS_A_LINE && wdata == `URBS_LINE_KEY
    |=> enh650_open_q)
    else $error("key write did not open 650 set");

  key_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stb && addr == `URBS_A_LINE && wdata == `URBS_LINE_KEY
    |=> line_control_q == {1'b1, $past(line_control_q[6:0])})
    else $error("key write changed format bits");

  divisor_write_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr_stb && line_control_q[7] && addr == `URBS_A_DATA
    |=> divisor_low_q == $past(wdata) && !tx_load_q)
    else $error("divisor low byte not written");

  divisor_read_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    rd_stb && line_control_q[7] && addr == `URBS_A_INTEN
    |=> rdata_q == $past(divisor_high_byte_q))
    else $error("divisor high byte not returned");

  adv_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stb && !line_control_q[7] && additional_control_q[7] &&
    addr == `URBS_A_MODEM |=> rdata_q == $past(tx_level))
    else $error("950 register not returned");

  idx_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stb && !line_control_q[7] && !additional_control_q[7] &&
    additional_control_q[6] && addr == `URBS_A_LSR
    |=> rdata_q == $past(idx_rdata))
    else $error("indexed register not returned");

  // back to back writes keep the pulse high
  tx_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stb && !line_control_q[7] && addr == `URBS_A_DATA
    |=> tx_load_q && tx_holding_q == $past(wdata)
    ##1 (tx_load_q == ($past(wr_stb) && !$past(line_control_q[7]) &&
                       $past(addr) == `URBS_A_DATA)))
    else $error("tx holding load wrong");

  ident_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stb && !line_control_q[7] && addr == `URBS_A_FIFO
    |=> rdata_q == $past(int_ident) && !rx_read_q)
    else $error("ident not returned");
endmodule : urbs_top

// file: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top
  import urbs_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic       wr_stb, rd_stb, tx_load_q, rx_read_q, fifo_wr_q;
  logic       enh650_open_q;
  urbs_byte_t wdata, rdata_q, tx_holding_q, fifo_control_q, int_enable_q;
  urbs_byte_t line_control_q, modem_control_q, divisor_low_q, enh_flow_q;
  urbs_byte_t divisor_high_byte_q, additional_control_q, v;
  urbs_byte_t rx_data = 8'h11, int_ident = 8'hc1, line_status = 8'h60;
  urbs_byte_t modem_status = 8'hb0, adv_status = 8'h2a;
  urbs_byte_t rx_level = 8'h05, tx_level = 8'h09;
  int         n_fail, samples_checked, cycles;

  urbs_top i_dut (.clk, .rst_n, .addr, .wr_stb, .rd_stb, .wdata, .rdata_q,
    .rx_data, .int_ident, .line_status, .modem_status, .adv_status,
    .rx_level, .tx_level, .tx_holding_q, .tx_load_q, .rx_read_q,
    .fifo_control_q, .fifo_wr_q, .int_enable_q, .line_control_q,
    .modem_control_q, .divisor_low_q, .divisor_high_byte_q,
    .additional_control_q, .enh_flow_q, .enh650_open_q);

  urbs_host i_host (.clk, .addr, .wr_stb, .rd_stb, .wdata, .rdata_q);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic t_normal();
    i_host.wr(3'h0, 8'h5a);
    #1;
    `CHK("tx_holding", 8'h5a, tx_holding_q)
    `CHK("tx_load", 1'b1, tx_load_q)
    i_host.rd(3'h0, v);
    `CHK("rx_data", rx_data, v)
    `CHK("rx_read", 1'b1, rx_read_q)
    i_host.wr(3'h2, 8'hc7);
    #1;
    `CHK("fifo_control", 8'hc7, fifo_control_q)
    `CHK("fifo_wr", 1'b1, fifo_wr_q)
    i_host.rd(3'h2, v);
    `CHK("int_ident", int_ident, v)
    i_host.wr(3'h4, 8'h0b);
    #1;
    `CHK("modem_control", 8'h0b, modem_control_q)
    i_host.rd(3'h6, v);
    `CHK("modem_status", modem_status, v)
  endtask : t_normal

  task automatic t_divisor();
    i_host.wr(3'h3, 8'h83);
    i_host.wr(3'h0, 8'h12);
    i_host.wr(3'h1, 8'h34);
    #1;
    `CHK("div_low", 8'h12, divisor_low_q)
    `CHK("div_high", 8'h34, divisor_high_byte_q)
    `CHK("tx_kept", 8'h5a, tx_holding_q)
    `CHK("int_enable_kept", 8'h00, int_enable_q)
    i_host.rd(3'h0, v);
    `CHK("div_rd", 8'h12, v)
    i_host.rd(3'h1, v);
    `CHK("div_high_rd", 8'h34, v)
  endtask : t_divisor

  task automatic t_key();
    i_host.wr(3'h3, 8'h03);
    i_host.wr(3'h3, 8'hbf);
    #1;
    `CHK("line_key", 8'h83, line_control_q)
    `CHK("open650", 1'b1, enh650_open_q)
    i_host.wr(3'h2, 8'hd0);
    #1;
    `CHK("enh_flow", 8'hd0, enh_flow_q)
    `CHK("fifo_kept", 8'hc7, fifo_control_q)
    i_host.rd(3'h2, v);
    `CHK("enh_rd", 8'hd0, v)
    i_host.wr(3'h4, 8'h3c);
    i_host.wr(3'h7, 8'h4d);
    i_host.rd(3'h4, v);
    `CHK("enh_char_first", 8'h3c, v)
    i_host.rd(3'h7, v);
    `CHK("enh_char_last", 8'h4d, v)
    `CHK("modem_kept", 8'h0b, modem_control_q)
    i_host.wr(3'h3, 8'h03);
    i_host.wr(3'h0, 8'ha5);
    #1;
    `CHK("closed650", 1'b0, enh650_open_q)
    `CHK("tx_back", 8'ha5, tx_holding_q)
  endtask : t_key

  task automatic t_acr();
    i_host.wr(3'h7, 8'h03);
    i_host.wr(3'h5, 8'h77);
    i_host.wr(3'h7, 8'h00);
    i_host.wr(3'h5, 8'h80);
    #1;
    `CHK("add_control", 8'h80, additional_control_q)
    i_host.rd(3'h1, v);
    `CHK("adv_status", adv_status, v)
    i_host.rd(3'h3, v);
    `CHK("rx_level", rx_level, v)
    i_host.rd(3'h4, v);
    `CHK("tx_level", tx_level, v)
    i_host.rd(3'h5, v);
    `CHK("status_plain", line_status, v)
    i_host.wr(3'h5, 8'h40);
    i_host.wr(3'h7, 8'h03);
    i_host.rd(3'h5, v);
    `CHK("idx_rd", 8'h77, v)
    i_host.rd(3'h3, v);
    `CHK("line_rd", 8'h03, v)
    i_host.rd(3'h7, v);
    `CHK("scratch_rd", 8'h03, v)
  endtask : t_acr

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("line_rst", 8'h00, line_control_q)
    t_normal();
    t_divisor();
    t_key();
    t_acr();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("line_rst2", 8'h00, line_control_q)
    `CHK("add_rst", 8'h00, additional_control_q)
    `CHK("open_rst", 1'b0, enh650_open_q)
    results();
  end
endmodule : tb_top

// file: verification/urbs_host.sv
`timescale 1ns/1ps
module urbs_host
  import urbs_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output logic [2:0]      addr,
  output logic            wr_stb,
  output logic            rd_stb,
  output urbs_byte_t      wdata,
  input  wire urbs_byte_t rdata_q
);
  initial begin
    addr   = 3'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata  = 8'h00;
  end

  task automatic wr(input logic [2:0] a, input urbs_byte_t d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata  <= ~d; // released data does not hold
  endtask : wr

  task automatic rd(input logic [2:0] a, output urbs_byte_t d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata_q;
  endtask : rd
endmodule : urbs_host
